// [common/supervisor_params.svh]
// offsets, field positions, reset values and timing figures of the supervisor
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH
// clock and time figures
`define CLK_MHZ 125
`define MS_US 1000
`define RST_FILTER_US 10
`define RST_DELAY_US 10000
`define LONG_WIN_MS 200
`define CLAMP_SETTLE 3'h4
`define WD_CLOSED_PCT 16'h003c
`define PCT_FULL 16'h0064
// watchdog periods in ms, setting 1 to 7
`define WD_P1_MS 10'h00a
`define WD_P2_MS 10'h014
`define WD_P3_MS 10'h032
`define WD_P4_MS 10'h064
`define WD_P5_MS 10'h0c8
`define WD_P6_MS 10'h1f4
`define WD_P7_MS 10'h3e8
// register bus byte offsets
`define OFF_STATUS 8'h00
`define OFF_WDCFG 8'h04
`define OFF_SUPCFG 8'h08
// device status fields
`define ST_MODE_LSB 0
`define ST_UV 3
`define ST_CLAMP 4
`define ST_SPIF 5
`define ST_WDF_LSB 6
`define ST_DEV 8
// watchdog config fields and reset value (200 ms, time-out, even parity)
`define WD_PER_LSB 0
`define WD_LIM 4
`define WD_WINDOW_SELECT 5
`define WD_CFG_RST 8'h05
`define SUP_CFG_RST 2'h0
// serial frame layout
`define SER_WR 7
`define SER_ADDR_MODE 7'h01
`define SER_ADDR_WD 7'h03
`define FRAME_BITS 5'h10
`define MODE_NORMAL 2'h0
`define MODE_SLEEP 2'h1
`define MODE_STOP 2'h2
`define MODE_SOFT 2'h3
`endif

// [common/supervisor_pkg.sv]
// types shared by the supervisor modules
package supervisor_pkg;
    typedef enum logic [2:0] {M_INIT, M_NORMAL, M_STOP, M_SLEEP, M_RESTART} sbc_mode_e;
    typedef enum logic [1:0] {RS_LOW, RS_DELAY, RS_HIGH} rst_state_e;
endpackage

// [hdl/serial_frame_rx.sv]
// serial port frame receiver, sampled on the system clock
`timescale 1ns/1ps
`include "supervisor_params.svh"
module serial_frame_rx (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ser_clk_pin,
    input wire logic ser_csn_pin,
    input wire logic ser_mosi_pin,
    output logic frame_stb,
    output logic frame_ok,
    output logic [15:0] frame_word
);
    logic [2:0] raw;
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic sclk_d_q;
    logic csn_d_q;
    logic [15:0] sr_q;
    logic [4:0] cnt_q;
    logic sclk_rise;
    logic cs_rise;

    assign raw = {ser_mosi_pin, ser_csn_pin, ser_clk_pin};

    // two-stage synchronisers on each pin
    for (genvar i = 0; i < 3; i++) begin : g_sync
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                meta_q[i] <= 1'b1;
                sync_q[i] <= 1'b1;
            end else begin
                meta_q[i] <= raw[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end

    assign sclk_rise = sync_q[0] && !sclk_d_q;
    assign cs_rise = sync_q[1] && !csn_d_q;

    // edge history, shift register and bit count (lsb first)
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_d_q <= 1'b1;
            csn_d_q <= 1'b1;
            sr_q <= 16'h0000;
            cnt_q <= 5'h00;
        end else begin
            sclk_d_q <= sync_q[0];
            csn_d_q <= sync_q[1];
            if (csn_d_q && sync_q[1]) begin
                cnt_q <= 5'h00;
            end else if (!sync_q[1] && sclk_rise) begin
                sr_q <= {sync_q[2], sr_q[15:1]};
                if (cnt_q != 5'h1f) begin
                    cnt_q <= cnt_q + 5'h01;
                end
            end
        end
    end

    // frame delivered when chip select rises
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_stb <= 1'b0;
            frame_ok <= 1'b0;
            frame_word <= 16'h0000;
        end else begin
            frame_stb <= cs_rise;
            if (cs_rise) begin
                frame_ok <= (cnt_q == `FRAME_BITS);
                frame_word <= sr_q;
            end
        end
    end
endmodule

// [hdl/reset_and_watchdog_supervisor.sv]
// reset output, clamp monitor, soft reset and watchdog of the supervisor
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "supervisor_params.svh"
module reset_and_watchdog_supervisor
    import supervisor_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `MS_US * `CLK_MHZ,
    parameter int unsigned RST_FILTER_CYC = `RST_FILTER_US * `CLK_MHZ,
    parameter int unsigned RST_DELAY_CYC = `RST_DELAY_US * `CLK_MHZ,
    parameter int unsigned LONG_WIN_MS = `LONG_WIN_MS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic ser_clk_pin,
    input wire logic ser_csn_pin,
    input wire logic ser_mosi_pin,
    input wire logic supply_uv_pin,
    input wire logic reset_pin_sense,
    input wire logic wake_pin,
    input wire logic dev_mode_pin,
    output logic reset_out_pin_o,
    output logic reset_out_pin_oe,
    output logic [1:0] uv_threshold_sel
);
    localparam logic [15:0] FILT_LAST = 16'(RST_FILTER_CYC - 1);
    localparam logic [23:0] DLY_LAST = 24'(RST_DELAY_CYC - 1);
    localparam logic [16:0] PRE_LAST = 17'(MS_CYCLES - 1);
    localparam logic [9:0] LW_LAST = 10'(LONG_WIN_MS - 1);

    // period code to milliseconds; code 0 is not a setting
    function automatic logic [9:0] period_ms(input logic [2:0] code);
        unique case (code)
            3'h1: period_ms = `WD_P1_MS;
            3'h2: period_ms = `WD_P2_MS;
            3'h3: period_ms = `WD_P3_MS;
            3'h4: period_ms = `WD_P4_MS;
            3'h5: period_ms = `WD_P5_MS;
            3'h6: period_ms = `WD_P6_MS;
            3'h7: period_ms = `WD_P7_MS;
            default: period_ms = `WD_P1_MS;
        endcase
    endfunction

    logic [3:0] pin_raw;
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic uv_now;
    logic pin_high;
    logic wake;
    logic dev;
    logic frame_stb;
    logic frame_ok;
    logic [15:0] frame_word;
    logic [7:0] ser_data;
    logic ser_wr_ok;
    logic wd_wr;
    logic parity_ok;
    logic mode_cmd;
    logic [1:0] mode_code;
    logic soft_rst;
    logic spi_err;
    sbc_mode_e mode_q;
    rst_state_e rs_q;
    logic [15:0] filt_q;
    logic uv_filt;
    logic [23:0] dly_q;
    logic cause_wd_q;
    logic rel_stb;
    logic rst_req;
    logic reset_low;
    logic [2:0] settle_q;
    logic clamp_hit;
    logic [7:0] wd_cfg_q;
    logic [16:0] pre_q;
    logic [9:0] ms_q;
    logic lw_q;
    logic [1:0] fail_cnt_q;
    logic wd_on;
    logic ms_tick;
    logic [9:0] period;
    logic [15:0] closed_prod;
    logic [9:0] closed_ms;
    logic wd_serve;
    logic early;
    logic expire;
    logic wd_failure_bits;
    logic wd_failure_bits_rst;
    logic uv_flag_q;
    logic clamp_flag_q;
    logic spif_q;
    logic [1:0] sup_cfg_q;
    logic aw_got_q;
    logic w_got_q;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_write;
    logic [7:0] w1c;
    logic [31:0] status_word;

    assign pin_raw = {dev_mode_pin, wake_pin, reset_pin_sense, supply_uv_pin};

    // two-stage synchronisers on the analog and pin inputs
    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= pin_raw[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end

    assign uv_now = sync_q[0];
    assign pin_high = sync_q[1];
    assign wake = sync_q[2];
    assign dev = sync_q[3];

    serial_frame_rx u_rx (
        .aclk(aclk),
        .aresetn(aresetn),
        .ser_clk_pin(ser_clk_pin),
        .ser_csn_pin(ser_csn_pin),
        .ser_mosi_pin(ser_mosi_pin),
        .frame_stb(frame_stb),
        .frame_ok(frame_ok),
        .frame_word(frame_word)
    );

    // serial command decode at chip select rise
    assign ser_data = frame_word[15:8];
    assign ser_wr_ok = frame_stb && frame_ok && frame_word[`SER_WR];
    assign wd_wr = ser_wr_ok && (frame_word[6:0] == `SER_ADDR_WD);
    assign parity_ok = ~^ser_data;
    assign mode_cmd = ser_wr_ok && (frame_word[6:0] == `SER_ADDR_MODE);
    assign mode_code = ser_data[1:0];
    assign soft_rst = mode_cmd && (mode_code == `MODE_SOFT)
        && (mode_q == M_NORMAL || mode_q == M_STOP);
    assign spi_err = (frame_stb && !frame_ok) || (wd_wr && !parity_ok);

    // undervoltage filter
    always_ff @(posedge aclk) begin
        if (!aresetn || !uv_now) begin
            filt_q <= 16'h0000;
        end else if (filt_q != FILT_LAST) begin
            filt_q <= filt_q + 16'h0001;
        end
    end
    assign uv_filt = uv_now && (filt_q == FILT_LAST);

    // reset output sequencer
    assign rel_stb = (rs_q == RS_DELAY) && !uv_filt && (dly_q == DLY_LAST);
    assign rst_req = wd_failure_bits_rst || (mode_q == M_SLEEP && wake);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rs_q <= RS_LOW;
            dly_q <= 24'h000000;
            cause_wd_q <= 1'b0;
        end else begin
            unique case (rs_q)
                RS_LOW: begin
                    dly_q <= 24'h000000;
                    if (!uv_now) begin
                        rs_q <= RS_DELAY;
                    end
                end
                RS_DELAY: begin
                    if (uv_filt) begin
                        rs_q <= RS_LOW;
                        cause_wd_q <= 1'b0;
                    end else if (rel_stb) begin
                        rs_q <= RS_HIGH;
                    end else begin
                        dly_q <= dly_q + 24'h000001;
                    end
                end
                RS_HIGH: begin
                    dly_q <= 24'h000000;
                    if (uv_filt) begin
                        rs_q <= RS_LOW;
                        cause_wd_q <= 1'b0;
                    end else if (rst_req) begin
                        rs_q <= RS_DELAY;
                        cause_wd_q <= wd_failure_bits_rst;
                    end
                end
            endcase
        end
    end
    assign reset_low = (rs_q != RS_HIGH);
    assign reset_out_pin_o = 1'b0;
    assign reset_out_pin_oe = reset_low;

    // settle time before the pin feedback is trusted
    always_ff @(posedge aclk) begin
        if (!aresetn || !reset_low) begin
            settle_q <= 3'h0;
        end else if (settle_q != `CLAMP_SETTLE) begin
            settle_q <= settle_q + 3'h1;
        end
    end

    // reset clamp detection
    assign clamp_hit = reset_low && pin_high && (settle_q == `CLAMP_SETTLE)
        && (mode_q == M_NORMAL || mode_q == M_STOP || mode_q == M_RESTART)
        && (cause_wd_q ? !uv_flag_q : !uv_now);

    // operating mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= M_INIT;
        end else begin
            unique case (mode_q)
                M_INIT: begin
                    if (wd_failure_bits_rst) begin
                        mode_q <= M_RESTART;
                    end else if (mode_cmd && mode_code == `MODE_NORMAL && !reset_low) begin
                        mode_q <= M_NORMAL;
                    end
                end
                M_NORMAL, M_STOP: begin
                    if (soft_rst) begin
                        mode_q <= M_INIT;
                    end else if (wd_failure_bits_rst || uv_filt) begin
                        mode_q <= M_RESTART;
                    end else if (mode_cmd && mode_code == `MODE_SLEEP && mode_q == M_NORMAL) begin
                        mode_q <= M_SLEEP;
                    end else if (mode_cmd && mode_code == `MODE_STOP) begin
                        mode_q <= M_STOP;
                    end else if (mode_cmd && mode_code == `MODE_NORMAL) begin
                        mode_q <= M_NORMAL;
                    end
                end
                M_SLEEP: begin
                    if (wake) begin
                        mode_q <= M_RESTART;
                    end
                end
                M_RESTART: begin
                    if (rel_stb) begin
                        mode_q <= M_NORMAL;
                    end
                end
            endcase
        end
    end

    // watchdog decode
    assign wd_on = !dev && ((mode_q == M_INIT && !reset_low)
        || mode_q == M_NORMAL || mode_q == M_STOP);
    assign ms_tick = (pre_q == PRE_LAST);
    assign period = period_ms(wd_cfg_q[`WD_PER_LSB +: 3]);
    assign closed_prod = 16'(period) * `WD_CLOSED_PCT;
    assign closed_ms = 10'(closed_prod / `PCT_FULL);
    assign wd_serve = wd_wr && parity_ok && wd_on;
    assign early = wd_serve && wd_cfg_q[`WD_WINDOW_SELECT] && !lw_q && (ms_q < closed_ms);
    assign expire = wd_on && ms_tick && (ms_q == (lw_q ? LW_LAST : period - 10'h001));
    assign wd_failure_bits = expire || early;
    assign wd_failure_bits_rst = wd_failure_bits && !(wd_cfg_q[`WD_LIM] && fail_cnt_q == 2'h3);

    // watchdog timer
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst || rel_stb) begin
            pre_q <= 17'h00000;
            ms_q <= 10'h000;
            lw_q <= 1'b1;
        end else if (!wd_on) begin
            pre_q <= 17'h00000;
            ms_q <= 10'h000;
        end else if (wd_failure_bits || wd_serve) begin
            pre_q <= 17'h00000;
            ms_q <= 10'h000;
            lw_q <= 1'b0;
        end else if (ms_tick) begin
            pre_q <= 17'h00000;
            ms_q <= ms_q + 10'h001;
        end else begin
            pre_q <= pre_q + 17'h00001;
        end
    end

    // watchdog configuration and failure count
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst) begin
            wd_cfg_q <= `WD_CFG_RST;
            fail_cnt_q <= 2'h0;
        end else begin
            if (wd_serve && !early && mode_q == M_NORMAL) begin
                wd_cfg_q <= ser_data;
            end
            if (wd_failure_bits && fail_cnt_q != 2'h3) begin
                fail_cnt_q <= fail_cnt_q + 2'h1;
            end else if (wd_serve && !early) begin
                fail_cnt_q <= 2'h0;
            end
        end
    end

    // sticky status flags, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst) begin
            uv_flag_q <= 1'b0;
            clamp_flag_q <= 1'b0;
            spif_q <= 1'b0;
        end else begin
            uv_flag_q <= (uv_filt && mode_q != M_SLEEP) || (uv_flag_q && !w1c[`ST_UV]);
            clamp_flag_q <= clamp_hit || (clamp_flag_q && !w1c[`ST_CLAMP]);
            spif_q <= spi_err || (spif_q && !w1c[`ST_SPIF]);
        end
    end

    // supply threshold select
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst) begin
            sup_cfg_q <= `SUP_CFG_RST;
        end else if (do_write && waddr_q == `OFF_SUPCFG && wstrb_q[0]) begin
            sup_cfg_q <= wdata_q[1:0];
        end
    end
    assign uv_threshold_sel = sup_cfg_q;

    // bus write channel, address and data in either order
    assign awready = !aw_got_q && !bvalid;
    assign wready = !w_got_q && !bvalid;
    assign do_write = aw_got_q && w_got_q;
    assign w1c = (do_write && waddr_q == `OFF_STATUS && wstrb_q[0]) ? wdata_q[7:0] : 8'h00;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
        end else begin
            if (awvalid && awready) begin
                aw_got_q <= 1'b1;
                waddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_got_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (do_write) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (waddr_q == `OFF_STATUS || waddr_q == `OFF_WDCFG
                    || waddr_q == `OFF_SUPCFG) ? 2'h0 : 2'h2;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // bus read channel
    assign arready = !rvalid;
    assign status_word = {23'h000000, dev, fail_cnt_q, spif_q, clamp_flag_q, uv_flag_q, 3'(mode_q)};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= 2'h0;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= 2'h0;
            unique case (araddr)
                `OFF_STATUS: rdata <= status_word;
                `OFF_WDCFG: rdata <= {24'h000000, wd_cfg_q};
                `OFF_SUPCFG: rdata <= {30'h00000000, sup_cfg_q};
                default: begin
                    rdata <= 32'h00000000;
                    rresp <= 2'h2;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule

// [verif/supervisor_checker.sv]
// port assertions for the reset and watchdog supervisor
`timescale 1ns/1ps
module supervisor_checker #(
    parameter int unsigned RST_DELAY_CYC = 50
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic supply_uv_pin,
    input wire logic reset_out_pin_o,
    input wire logic reset_out_pin_oe,
    input wire logic [1:0] uv_threshold_sel
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [31:0] held_q;
    // cycles of reset held with supply good
    always_ff @(posedge aclk) begin
        if (!aresetn || !reset_out_pin_oe || supply_uv_pin) begin
            held_q <= 32'h0;
        end else begin
            held_q <= held_q + 32'h1;
        end
    end
    property p_pin_low;
        reset_out_pin_o == 1'b0;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("reset data not low");
    property p_oe_release;
        $rose(aresetn) |-> reset_out_pin_oe;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("reset not held");
    property p_uv_filter;
        supply_uv_pin [*8] |=> reset_out_pin_oe;
    endproperty
    a_uv_filter: assert property (p_uv_filter) else $error("undervolt no reset");
    property p_uv_hold;
        $fell(supply_uv_pin) && reset_out_pin_oe |=> reset_out_pin_oe [*8];
    endproperty
    a_uv_hold: assert property (p_uv_hold) else $error("reset delay short");
    property p_release_bound;
        held_q <= RST_DELAY_CYC + 8;
    endproperty
    a_release_bound: assert property (p_release_bound) else $error("reset too long");
    property p_thr_reset;
        $rose(aresetn) |-> uv_threshold_sel == 2'h0;
    endproperty
    a_thr_reset: assert property (p_thr_reset) else $error("threshold not lowest");
    property p_thr_change;
        $changed(uv_threshold_sel) |-> $rose(bvalid) || uv_threshold_sel == 2'h0;
    endproperty
    a_thr_change: assert property (p_thr_change) else $error("threshold moved");
    property p_write_answer;
        awvalid && awready && wvalid && wready |-> ##2 bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("no write answer");
    property p_read_answer;
        arvalid && arready |=> rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("no read answer");
endmodule
bind reset_and_watchdog_supervisor supervisor_checker #(.RST_DELAY_CYC(RST_DELAY_CYC)) supervisor_checker_inst (
    .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid,
    .supply_uv_pin, .reset_out_pin_o, .reset_out_pin_oe, .uv_threshold_sel
);

// [verif/host_mcu_model.sv]
// host serial port model, one frame per request
`timescale 1ns/1ps
module host_mcu_model (
    input wire logic aclk,
    input wire logic send,
    input wire logic [15:0] word,
    output logic ser_clk_pin,
    output logic ser_csn_pin,
    output logic ser_mosi_pin,
    output logic busy
);
    initial begin
        ser_clk_pin = 1'b0;
        ser_csn_pin = 1'b1;
        ser_mosi_pin = 1'b0;
        busy = 1'b0;
    end
    // lsb first, link clock still outside frames
    always @(posedge aclk) begin
        if (send) begin
            #1 busy = 1'b1;
            ser_csn_pin = 1'b0;
            for (int i = 0; i < 16; i++) begin
                ser_mosi_pin = word[i];
                #40 ser_clk_pin = 1'b1;
                #40 ser_clk_pin = 1'b0;
            end
            #40 ser_csn_pin = 1'b1;
            ser_mosi_pin = !ser_mosi_pin;
            busy = 1'b0;
        end
    end
endmodule

// [verif/tb.sv]
// self-checking bench for the reset and watchdog supervisor
`timescale 1ns/1ps
module tb;
    typedef struct {string n; logic [33:0] e; logic [33:0] m;} note_s;
    note_s notes[$];
    note_s nt;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic bready = 1'b1, rready = 1'b1, wake_pin = 1'b0, dev_mode_pin = 1'b0, send = 1'b0;
    logic supply_uv_pin = 1'b0, clamp = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic [15:0] word = 16'h0;
    logic awready, wready, bvalid, arready, rvalid, reset_out_pin_o, reset_out_pin_oe, busy;
    logic ser_clk_pin, ser_csn_pin, ser_mosi_pin, reset_pin_sense;
    logic [1:0] bresp, rresp, uv_threshold_sel, rnd;
    logic [31:0] rdata;
    int num_errors = 0;
    int samples_checked = 0;
    int seed = 99;
    always #4 aclk = !aclk;
    // pull-up on the reset pin unless held high from outside
    assign reset_pin_sense = clamp | !reset_out_pin_oe;
    reset_and_watchdog_supervisor #(.MS_CYCLES(20), .RST_FILTER_CYC(4), .RST_DELAY_CYC(50), .LONG_WIN_MS(30)
    ) reset_and_watchdog_supervisor_inst (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .ser_clk_pin, .ser_csn_pin, .ser_mosi_pin, .supply_uv_pin, .reset_pin_sense, .wake_pin,
        .dev_mode_pin, .reset_out_pin_o, .reset_out_pin_oe, .uv_threshold_sel
    );
    host_mcu_model host_mcu_model_inst (.aclk, .send, .word, .ser_clk_pin, .ser_csn_pin, .ser_mosi_pin, .busy);
    task automatic compare(input string n, input logic [33:0] e, input logic [33:0] s);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // read answers against the oldest note
    always @(negedge aclk) begin
        if (rvalid === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            compare(nt.n, nt.e, {rresp, rdata} & nt.m);
        end
    end
    task automatic rd(input string n, input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
        int k;
        k = 0;
        notes.push_back('{n, e, m});
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            k++;
        end while (arready !== 1'b1 && k < 50);
        @(posedge aclk);
        arvalid <= 1'b0;
        while (notes.size() > 0 && k < 60) begin
            @(posedge aclk);
            k++;
        end
        // an unanswered read counts as a mismatch
        if (notes.size() > 0) begin
            num_errors++;
            notes.delete();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw;
        int k;
        k = 0;
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a;
        wdata <= d;
        while ((pa || pw) && k < 50) begin
            awvalid <= pa;
            wvalid <= pw;
            @(negedge aclk);
            pa = pa && awready !== 1'b1;
            pw = pw && wready !== 1'b1;
            @(posedge aclk);
            k++;
        end
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do begin
            @(negedge aclk);
            k++;
        end while (bvalid !== 1'b1 && k < 60);
        compare("write answer", 34'h4, {31'h0, bvalid, bresp});
        @(posedge aclk);
    endtask
    task automatic ser(input logic [15:0] w);
        word <= w;
        send <= 1'b1;
        @(posedge aclk);
        send <= 1'b0;
        @(posedge aclk);
        while (busy) @(posedge aclk);
        repeat (6) @(posedge aclk);
    endtask
    task automatic wait_oe(input logic v, input int lim);
        int k;
        k = 0;
        do begin
            @(negedge aclk);
            k++;
        end while (reset_out_pin_oe !== v && k < lim);
        compare("reset output", {33'h0, v}, {33'h0, reset_out_pin_oe});
        @(posedge aclk);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge aclk);
        wait_oe(1'b1, 1);
        compare("threshold", 34'h0, {32'h0, uv_threshold_sel});
        aresetn <= 1'b1;
        repeat (20) @(posedge aclk);
        wait_oe(1'b1, 1);
        wait_oe(1'b0, 60);
        rd("status", 8'h00, 34'h0, 34'h3_0000_003f);
        rd("wd config", 8'h04, 34'h5, 34'h3_0000_00ff);
        rd("unmapped", 8'h0c, 34'h2_0000_0000, 34'h3_ffff_ffff);
        rnd = 2'($random(seed));
        wr(8'h08, {30'h0, rnd});
        rd("supply cfg", 8'h08, {32'h0, rnd}, 34'h3_0000_0003);
        compare("threshold", {32'h0, rnd}, {32'h0, uv_threshold_sel});
        $display("test power-up done");
        ser(16'h0081);
        ser(16'h0183);
        rd("serial error", 8'h00, 34'h20, 34'h3_0000_0020);
        rd("wd config", 8'h04, 34'h5, 34'h3_0000_00ff);
        wr(8'h00, 32'h20);
        repeat (3) ser(16'h8183);
        rd("wd config", 8'h04, 34'h81, 34'h3_0000_00ff);
        clamp <= 1'b1;
        repeat (150) @(posedge aclk);
        wait_oe(1'b0, 1);
        wait_oe(1'b1, 100);
        repeat (10) @(posedge aclk);
        rd("restart", 8'h00, 34'h54, 34'h3_0000_00ff);
        clamp <= 1'b0;
        wait_oe(1'b0, 80);
        rd("normal", 8'h00, 34'h51, 34'h3_0000_00df);
        $display("test timeout watchdog done");
        ser(16'h0381);
        compare("soft reset", 34'h0, {33'h0, reset_out_pin_oe});
        rd("soft mode", 8'h00, 34'h0, 34'h3_0000_0007);
        rd("soft wd config", 8'h04, 34'h5, 34'h3_0000_00ff);
        compare("soft threshold", 34'h0, {32'h0, uv_threshold_sel});
        wr(8'h08, 32'h2);
        ser(16'h0381);
        rd("init soft", 8'h08, 34'h2, 34'h3_0000_0003);
        ser(16'h8183);
        rd("init wd config", 8'h04, 34'h5, 34'h3_0000_00ff);
        $display("test soft reset done");
        supply_uv_pin <= 1'b1;
        wait_oe(1'b1, 12);
        repeat (30) @(posedge aclk);
        supply_uv_pin <= 1'b0;
        repeat (40) @(posedge aclk);
        wait_oe(1'b1, 1);
        wait_oe(1'b0, 30);
        rd("uv flag", 8'h00, 34'h8, 34'h3_0000_0008);
        $display("test undervoltage done");
        ser(16'h0081);
        ser(16'ha383);
        ser(16'ha383);
        wait_oe(1'b1, 20);
        $display("test window watchdog done");
        wait_oe(1'b0, 80);
        dev_mode_pin <= 1'b1;
        repeat (700) @(posedge aclk);
        wait_oe(1'b0, 1);
        rd("dev mode", 8'h00, 34'h101, 34'h3_0000_0107);
        $display("test development mode done");
        print_verdict;
    end
    // hang guard
    initial begin
        #200000;
        num_errors++;
        print_verdict;
    end
endmodule
